// file: verilog/idt_pkg.sv
// Constants, field layouts and decoded-instruction type for the decoder.
// Assumes 16-bit program words and a 32-bit Avalon-MM register master.
package idt_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_FLAGS = 5'h04;
  localparam logic [4:0] OFF_TBL_POINTER = 5'h08;
  localparam logic [4:0] OFF_BANK = 5'h0c;
  localparam logic [4:0] OFF_INFO = 5'h10;
  localparam logic [4:0] OFF_RETIRED = 5'h14;
  localparam int CTRL_EXT_BIT = 0;
  localparam logic [4:0] RST_FLAGS = 5'h00;
  localparam logic [20:0] RST_TBL_POINTER = 21'h0_0000;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic RST_EXT_EN = 1'b0;

  // ----------------------------------------------------------------
  // Instruction fields, flag layout and timing
  // ----------------------------------------------------------------
  localparam int POS_D = 9;
  localparam int POS_A = 8;
  localparam int POS_BIT = 9;
  localparam logic [3:0] WORD2_TAG = 4'hf;
  localparam logic [7:0] ACC_SPLIT = 8'h80;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;
  localparam int FLG_C = 0;
  localparam int FLG_DIGIT = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OVF = 3;
  localparam int FLG_N = 4;
  localparam logic [4:0] FM_ALL = 5'h1f;
  localparam logic [4:0] FM_ZN = 5'h14;
  localparam logic [4:0] FM_CZN = 5'h15;
  localparam logic [4:0] FM_Z = 5'h04;
  localparam logic [4:0] FM_C = 5'h01;
  localparam int QUARTERS = 4;
  localparam logic [1:0] Q_LAST = 2'(QUARTERS - 1);

  typedef enum logic [1:0] {GRP_BYTE, GRP_BIT, GRP_LIT, GRP_CTRL} idt_grp_t;
  typedef enum logic [1:0] {TM_NONE, TM_POSTINC, TM_POSTDEC, TM_PREINC}
    idt_tmode_t;

  typedef struct packed {
    idt_grp_t grp;
    logic two_word;
    logic pc_chg;
    logic cond;
    logic has_d;
    logic tbl;
    logic tbl_wr;
    logic movlb;
    logic lfsr;
    logic fast;
    logic call;
    logic ret;
    logic ext;
    idt_tmode_t tmode;
    logic [4:0] fmask;
    logic [1:0] ptr;
    logic [19:0] lit;
  } idt_dec_t;
endpackage

// file: verilog/idt_shadow_mem.sv
// Small register file holding fast-mode shadow copies.
// Assumes one writer and registered read data one clock after the address.
module idt_shadow_mem #(
  parameter int W = 17, // Bits per entry.
  parameter int D = 1 // Number of entries.
) (
  input wire logic mclk_i, // Core clock.
  input wire logic rstn_i, // Asynchronous reset, active low.
  input wire logic we_i, // Write strobe.
  input wire logic [((D > 1) ? $clog2(D) : 1)-1:0] waddr_i, // Write index.
  input wire logic [W-1:0] wdata_i, // Write data.
  input wire logic [((D > 1) ? $clog2(D) : 1)-1:0] raddr_i, // Read index.
  output logic [W-1:0] rdata_o // Registered read data.
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [W-1:0] mem_reg [D];

  // Entries clear at reset so a restore before any save is defined.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < D; i++) begin
        mem_reg[i] <= '0;
      end
      rdata_o <= '0;
    end else begin
      if (we_i) begin
        mem_reg[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_reg[raddr_i];
    end
  end
endmodule

// file: verilog/idt_core.sv
// Instruction decode and cycle timing for an 8-bit core, with registers.
// Assumes program words and datapath inputs synchronous to mclk_i.
module idt_core #(
  parameter int SHADOW_DEPTH = 1 // Shadow memory entries; only entry 0 is ever written or read.
) (
  input wire logic mclk_i, // Core clock, 125 MHz.
  input wire logic rstn_i, // Asynchronous reset, active low.
  input wire logic [4:0] address_i, // Avalon byte address.
  input wire logic read_i, // Avalon read.
  input wire logic write_i, // Avalon write.
  input wire logic [3:0] byteenable_i, // Avalon byte lanes.
  input wire logic [31:0] writedata_i, // Avalon write data.
  output logic [31:0] readdata_o, // Avalon read data.
  output logic waitrequest_o, // Avalon stall.
  input wire logic [15:0] instr_word_i, // Program word.
  input wire logic instr_valid_i, // Program word present.
  output logic instr_ready_o, // Program word taken.
  input wire logic cond_true_i, // Conditional test outcome.
  input wire logic [4:0] alu_flags_i, // Flags from the ALU.
  input wire logic [7:0] working_accumulator_i, // Accumulator value.
  output logic [1:0] q_phase_o, // Quarter within a cycle.
  output logic [1:0] state_o, // Cycle kind.
  output logic [1:0] group_o, // Instruction group.
  output logic dest_file_o, // Result to file register.
  output logic access_bank_o, // Bank select in use.
  output logic [7:0] file_addr_o, // Short file field.
  output logic [11:0] ram_addr_o, // Effective RAM address.
  output logic [2:0] bit_num_o, // Bit number.
  output logic [11:0] src_addr_o, // Move source.
  output logic [11:0] dst_addr_o, // Move destination.
  output logic [19:0] literal_o, // Literal or branch field.
  output logic [1:0] pointer_sel_o, // Indirect pointer number.
  output logic fast_o, // Fast mode selector.
  output logic retire_o, // Instruction completed.
  output logic [4:0] flags_o, // Status flags.
  output logic [3:0] bank_select_register_o, // Bank select.
  output logic [20:0] table_pointer_o, // Table pointer.
  output logic tbl_stb_o, // Table access pulse.
  output logic tbl_write_o, // Table access is a write.
  output logic [20:0] tbl_addr_o, // Table access address.
  output logic shadow_restore_o, // Shadow restore pulse.
  output logic [7:0] shadow_acc_o // Saved accumulator.
);
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WORD2, ST_NOP} idt_st_t;

  typedef struct packed {
    logic [1:0] q;
    idt_st_t st;
    logic [15:0] w1;
    idt_pkg::idt_dec_t dec;
    logic [11:0] ram_addr;
    logic [11:0] src;
    logic [11:0] dst;
    logic [4:0] flags;
    logic [20:0] table_pointer;
    logic [20:0] tbl_addr;
    logic tbl_stb;
    logic tbl_wr;
    logic [3:0] bank;
    logic ext_en;
    logic ack;
    logic [31:0] rdata;
    logic [31:0] retired;
    logic retire;
    logic restore;
    logic [1:0] cyc;
  } idt_state_t;

  idt_state_t s_reg;
  idt_state_t s_next;
  logic sh_we;
  logic [16:0] sh_wdata;
  logic [16:0] sh_rdata;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Lane-wise merge of a bus write into a register image.
  function automatic logic [31:0] be_merge(input logic [31:0] old,
    input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [11:0] eff_addr(input logic a,
    input logic [7:0] f, input logic [3:0] bank);
    logic [11:0] r;
    if (a) begin
      r = {bank, f};
    end else if (f < idt_pkg::ACC_SPLIT) begin
      r = {4'h0, f};
    end else begin
      r = {idt_pkg::ACC_HI_BANK, f};
    end
    return r;
  endfunction

  // First-word decode; unknown words and stray second words decode as
  // a plain one-cycle no-op so the fetch stream never stalls on them.
  function automatic idt_pkg::idt_dec_t decode(input logic [15:0] w,
    input logic ext);
    idt_pkg::idt_dec_t d;
    d = '0;
    d.lit = {12'h000, w[7:0]};
    case (w[15:12])
      4'h0: begin
        if (w[11:8] == 4'h0) begin
          d.grp = idt_pkg::GRP_CTRL;
          casez (w[7:0])
            8'b0000_0111: d.fmask = idt_pkg::FM_C;
            8'b0000_1???: begin
              d.tbl = 1'b1;
              d.tbl_wr = w[2];
              d.tmode = idt_pkg::idt_tmode_t'(w[1:0]);
            end
            8'b0001_00??: begin
              d.ret = 1'b1;
              d.pc_chg = 1'b1;
              d.fast = w[0];
            end
            8'b0001_0100: begin
              d.ext = ext;
              d.pc_chg = ext;
            end
            8'b1111_1111: d.pc_chg = 1'b1;
            default: d.ext = 1'b0;
          endcase
        end else if (w[11:8] == 4'h1) begin
          d.grp = idt_pkg::GRP_LIT;
          d.movlb = 1'b1;
          d.lit = {16'h0000, w[3:0]};
        end else if (w[11]) begin
          d.grp = idt_pkg::GRP_LIT;
          d.pc_chg = (w[10:8] == 3'h4);
          if (w[11:8] == 4'h8 || w[11:8] == 4'hf) begin
            d.fmask = idt_pkg::FM_ALL;
          end else if (w[11:10] == 2'b10 || w[11:8] == 4'hb) begin
            d.fmask = idt_pkg::FM_ZN;
          end
        end else begin
          d.has_d = (w[11:10] == 2'b01);
          d.fmask = d.has_d ? idt_pkg::FM_ALL : 5'h00;
        end
      end
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
        d.grp = idt_pkg::GRP_BYTE;
        d.has_d = (w[15:12] != 4'h6);
        casez (w[15:10])
          6'b0001_??, 6'b0100_0?, 6'b0101_00: d.fmask = idt_pkg::FM_ZN;
          6'b0010_0?, 6'b0010_10, 6'b0101_??: d.fmask = idt_pkg::FM_ALL;
          6'b0011_0?: d.fmask = idt_pkg::FM_CZN;
          6'b0010_11, 6'b0011_11, 6'b0100_1?: d.cond = 1'b1;
          6'b0110_0?: d.cond = ~w[10] | ~w[9];
          6'b0110_10: d.fmask = w[9] ? 5'h00 : idt_pkg::FM_Z;
          6'b0110_11: d.fmask = w[9] ? 5'h00 : idt_pkg::FM_ALL;
          default: d.fmask = 5'h00;
        endcase
      end
      4'h7, 4'h8, 4'h9, 4'ha, 4'hb: begin
        d.grp = idt_pkg::GRP_BIT;
        d.cond = (w[15:13] == 3'b101);
      end
      4'hc: begin
        d.grp = idt_pkg::GRP_BYTE;
        d.two_word = 1'b1;
      end
      4'hd: begin
        d.grp = idt_pkg::GRP_CTRL;
        d.pc_chg = 1'b1;
        d.call = w[11];
        d.lit = {9'h000, w[10:0]};
      end
      4'he: begin
        d.grp = idt_pkg::GRP_CTRL;
        if (!w[11]) begin
          d.cond = 1'b1;
        end else if (w[10:9] == 2'b00 || w[10:8] == 3'h3) begin
          d.ext = ext;
        end else if (w[10:9] == 2'b10) begin
          d.two_word = 1'b1;
          d.call = 1'b1;
          d.pc_chg = 1'b1;
          d.fast = w[8];
        end else if (w[8]) begin
          d.two_word = 1'b1;
          d.pc_chg = 1'b1;
        end else if (w[10:9] == 2'b11) begin
          d.grp = idt_pkg::GRP_LIT;
          d.two_word = 1'b1;
          d.lfsr = 1'b1;
          d.ptr = w[5:4];
        end
      end
      default: d.grp = idt_pkg::GRP_CTRL;
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Shadow store
  // ----------------------------------------------------------------
  assign sh_wdata = {working_accumulator_i, s_reg.flags, s_reg.bank};

  idt_shadow_mem #(
    .W(17),
    .D(SHADOW_DEPTH)
  ) u_shadow (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .we_i(sh_we),
    .waddr_i('0),
    .wdata_i(sh_wdata),
    .raddr_i('0),
    .rdata_o(sh_rdata)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic bnd;
  logic need_nop;
  logic done;
  logic req;

  // Bus writes are applied first so hardware updates in the same cycle
  // take priority over software.
  always_comb begin
    s_next = s_reg;
    s_next.retire = 1'b0;
    s_next.restore = 1'b0;
    s_next.tbl_stb = 1'b0;
    sh_we = 1'b0;
    req = read_i | write_i;
    s_next.ack = req & ~s_reg.ack;
    if (read_i && !s_reg.ack) begin
      if (address_i == idt_pkg::OFF_CTRL) begin
        s_next.rdata = {31'h0000_0000, s_reg.ext_en};
      end else if (address_i == idt_pkg::OFF_FLAGS) begin
        s_next.rdata = {27'h000_0000, s_reg.flags};
      end else if (address_i == idt_pkg::OFF_TBL_POINTER) begin
        s_next.rdata = {11'h000, s_reg.table_pointer};
      end else if (address_i == idt_pkg::OFF_BANK) begin
        s_next.rdata = {28'h000_0000, s_reg.bank};
      end else if (address_i == idt_pkg::OFF_INFO) begin
        s_next.rdata = {11'h000, s_reg.ext_en, s_reg.cyc,
          s_reg.dec.grp, s_reg.w1};
      end else if (address_i == idt_pkg::OFF_RETIRED) begin
        s_next.rdata = s_reg.retired;
      end else begin
        s_next.rdata = 32'h0000_0000;
      end
    end
    if (write_i && s_reg.ack) begin
      if (address_i == idt_pkg::OFF_CTRL) begin
        if (byteenable_i[0]) begin
          s_next.ext_en = writedata_i[idt_pkg::CTRL_EXT_BIT];
        end
      end else if (address_i == idt_pkg::OFF_FLAGS) begin
        s_next.flags = 5'(be_merge({27'h000_0000, s_reg.flags},
          writedata_i, byteenable_i));
      end else if (address_i == idt_pkg::OFF_TBL_POINTER) begin
        s_next.table_pointer = 21'(be_merge({11'h000, s_reg.table_pointer},
          writedata_i, byteenable_i));
      end else if (address_i == idt_pkg::OFF_BANK) begin
        s_next.bank = 4'(be_merge({28'h000_0000, s_reg.bank},
          writedata_i, byteenable_i));
      end
    end

    s_next.q = s_reg.q + 2'h1;
    bnd = (s_reg.q == idt_pkg::Q_LAST);
    need_nop = s_reg.dec.pc_chg | (s_reg.dec.cond & cond_true_i);
    done = bnd && ((s_reg.st == ST_EXEC && !s_reg.dec.two_word)
      || s_reg.st == ST_WORD2);
    instr_ready_o = bnd && (s_reg.st != ST_EXEC || s_reg.dec.two_word
      || !need_nop);

    if (bnd) begin
      case (s_reg.st)
        ST_EXEC: begin
          if (s_reg.dec.two_word) begin
            s_next.st = instr_valid_i ? ST_WORD2 : ST_EXEC;
          end else if (need_nop) begin
            s_next.st = ST_NOP;
          end else begin
            s_next.st = instr_valid_i ? ST_EXEC : ST_IDLE;
          end
        end
        default: s_next.st = instr_valid_i ? ST_EXEC : ST_IDLE;
      endcase
    end

    if (instr_ready_o && instr_valid_i) begin
      if (s_reg.st == ST_EXEC && s_reg.dec.two_word) begin
        s_next.dst = instr_word_i[11:0];
        if (s_reg.dec.lfsr) begin
          s_next.dec.lit = {8'h00, s_reg.w1[3:0], instr_word_i[7:0]};
        end else if (s_reg.dec.pc_chg) begin
          s_next.dec.lit = {instr_word_i[11:0], s_reg.w1[7:0]};
        end
      end else begin
        s_next.w1 = instr_word_i;
        s_next.dec = decode(instr_word_i, s_reg.ext_en);
        s_next.ram_addr = eff_addr(instr_word_i[idt_pkg::POS_A],
          instr_word_i[7:0], s_next.bank);
        s_next.src = instr_word_i[11:0];
      end
    end

    if (done) begin
      s_next.retire = 1'b1;
      s_next.retired = s_reg.retired + 32'h0000_0001;
      s_next.cyc = (s_reg.st == ST_WORD2 || need_nop) ? 2'h2 : 2'h1;
      s_next.flags = (s_next.flags & ~s_reg.dec.fmask)
        | (alu_flags_i & s_reg.dec.fmask);
      if (s_reg.dec.movlb) begin
        s_next.bank = s_reg.dec.lit[3:0];
      end
      if (s_reg.dec.tbl) begin
        s_next.tbl_stb = 1'b1;
        // Direction is latched with the strobe so a word taken at the
        // same edge cannot change it under the pulse.
        s_next.tbl_wr = s_reg.dec.tbl_wr;
        case (s_reg.dec.tmode)
          idt_pkg::TM_POSTINC: begin
            s_next.tbl_addr = s_reg.table_pointer;
            s_next.table_pointer = s_reg.table_pointer + 21'h0_0001;
          end
          idt_pkg::TM_POSTDEC: begin
            s_next.tbl_addr = s_reg.table_pointer;
            s_next.table_pointer = s_reg.table_pointer - 21'h0_0001;
          end
          idt_pkg::TM_PREINC: begin
            s_next.tbl_addr = s_reg.table_pointer + 21'h0_0001;
            s_next.table_pointer = s_reg.table_pointer + 21'h0_0001;
          end
          default: s_next.tbl_addr = s_reg.table_pointer;
        endcase
      end
      if (s_reg.dec.call && s_reg.dec.fast && s_reg.dec.two_word) begin
        sh_we = 1'b1;
      end
      if (s_reg.dec.ret && s_reg.dec.fast) begin
        s_next.restore = 1'b1;
        s_next.flags = sh_rdata[8:4];
        s_next.bank = sh_rdata[3:0];
      end
    end
  end

  // State register; every field runs on every clock edge.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg <= '0;
      s_reg.flags <= idt_pkg::RST_FLAGS;
      s_reg.table_pointer <= idt_pkg::RST_TBL_POINTER;
      s_reg.bank <= idt_pkg::RST_BANK;
      s_reg.ext_en <= idt_pkg::RST_EXT_EN;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // destination select out
  assign dest_file_o = s_reg.dec.has_d & s_reg.w1[idt_pkg::POS_D];
  assign access_bank_o = s_reg.w1[idt_pkg::POS_A];
  assign file_addr_o = s_reg.w1[7:0];
  assign bit_num_o = s_reg.w1[idt_pkg::POS_BIT +: 3];
  assign ram_addr_o = s_reg.ram_addr;
  assign src_addr_o = s_reg.src;
  assign dst_addr_o = s_reg.dst;
  assign literal_o = s_reg.dec.lit;
  assign pointer_sel_o = s_reg.dec.ptr;
  assign fast_o = s_reg.dec.fast;
  assign group_o = s_reg.dec.grp;
  assign q_phase_o = s_reg.q;
  assign state_o = s_reg.st;
  assign retire_o = s_reg.retire;
  assign flags_o = s_reg.flags;
  assign bank_select_register_o = s_reg.bank;
  assign table_pointer_o = s_reg.table_pointer;
  assign tbl_stb_o = s_reg.tbl_stb;
  assign tbl_write_o = s_reg.tbl_wr;
  assign tbl_addr_o = s_reg.tbl_addr;
  assign shadow_restore_o = s_reg.restore;
  assign shadow_acc_o = sh_rdata[16:9];
  assign readdata_o = s_reg.rdata;
  assign waitrequest_o = req & ~s_reg.ack;
endmodule

// file: dv/idt_checker.sv
// Port checker for the decoder core: quarters, retire timing, bus stall.
// Assumes it is bound to idt_core and sees one clock domain.
module idt_checker (
  input wire logic mclk_i, // Core clock.
  input wire logic rstn_i, // Reset, active low.
  input wire logic read_i, // Bus read.
  input wire logic write_i, // Bus write.
  input wire logic waitrequest_o, // Bus stall.
  input wire logic instr_ready_o, // Word taken.
  input wire logic [1:0] q_phase_o, // Quarter.
  input wire logic [1:0] state_o, // Cycle kind.
  input wire logic retire_o, // Completion pulse.
  input wire logic [4:0] flags_o // Status flags.
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Timing properties
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  // The first edge after reset is skipped because $past sees reset values.
  property p_q;
    $past(rstn_i) |-> q_phase_o == $past(q_phase_o) + 2'h1;
  endproperty
  a_q: assert property (p_q) else $error("quarter skipped");
  property p_rdy;
    instr_ready_o |-> q_phase_o == 2'h3;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready off quarter");
  property p_retq;
    retire_o |-> q_phase_o == 2'h0;
  endproperty
  a_retq: assert property (p_retq) else $error("retire off edge");
  property p_gap;
    retire_o |=> (!retire_o) [*3];
  endproperty
  a_gap: assert property (p_gap) else $error("retire too soon");
  // A forced no-op fills one whole instruction cycle.
  property p_nop;
    state_o == 2'h3 && q_phase_o == 2'h0 |-> (state_o == 2'h3) [*4];
  endproperty
  a_nop: assert property (p_nop) else $error("short no-op");
  property p_two;
    state_o == 2'h2 && q_phase_o == 2'h0 |->
      (state_o == 2'h2) [*4] ##1 retire_o;
  endproperty
  a_two: assert property (p_two) else $error("second word timing");
  property p_wait;
    (read_i || write_i) && waitrequest_o |=> !waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("bus wait too long");
  // Flags move only on retire or right after a bus write lands.
  property p_flg;
    $changed(flags_o) |-> retire_o || $past(write_i && !waitrequest_o);
  endproperty
  a_flg: assert property (p_flg) else $error("flags moved");
  c_two: cover property (state_o == 2'h2);
  c_nop: cover property (state_o == 2'h3);
  c_ret: cover property (retire_o);
endmodule

// file: dv/idt_progmem.sv
// Program memory model handing queued words to the decoder.
// Assumes the bench fills the queue through push; ready is a pulse.
module idt_progmem (
  input wire logic mclk_i, // Core clock.
  input wire logic rstn_i, // Reset, active low.
  input wire logic ready_i, // Word taken at this edge.
  input wire logic slow_i, // Hold the next word back.
  output logic [15:0] word_o = 16'h0000, // Program word.
  output logic valid_o = 1'b0 // Word present.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] q[$];
  // words of one instruction queued back to back.
  task automatic push(input logic [15:0] w);
    q.push_back(w);
  endtask
  // An idle word line flips every cycle so stale words never match.
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      valid_o <= 1'b0;
    end else if (!valid_o || ready_i) begin
      if (valid_o) void'(q.pop_front());
      valid_o <= q.size() > 0 && !slow_i;
      word_o <= (q.size() > 0 && !slow_i) ? q[0] : ~word_o;
    end
  end
endmodule

// file: dv/idt_core_test.sv
// Self-checking bench for the decoder core with a program memory model.
// Assumes the checker and the memory model are compiled before it.
module idt_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0, rstn_i = 1'b0, rd = 1'b0, wr = 1'b0, slow = 1'b0;
  logic ct = 1'b0, iv, irdy, df, ab, fst, ret, tstb, twr, srst;
  logic r_seen, w_seen, wt;
  logic [4:0] adr = 5'h00, af = 5'h00, fl;
  logic [7:0] acc = 8'h00, fa, swr;
  logic [31:0] wd = 32'h0000_0000, rdat;
  logic [15:0] iw;
  logic [1:0] grp, psel;
  logic [11:0] ra, sa, da;
  logic [2:0] bn;
  logic [3:0] bank_select_register;
  logic [19:0] lit;
  logic [20:0] tp, ta, t_seen;
  int n_mismatch = 0, compares = 0, n_ret = 0;
  idt_core u_idt_core (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .address_i(adr), .read_i(rd),
    .write_i(wr), .byteenable_i(4'hf), .writedata_i(wd),
    .readdata_o(rdat), .waitrequest_o(wt), .instr_word_i(iw),
    .instr_valid_i(iv), .instr_ready_o(irdy), .cond_true_i(ct),
    .alu_flags_i(af), .working_accumulator_i(acc), .q_phase_o(),
    .state_o(), .group_o(grp), .dest_file_o(df), .access_bank_o(ab),
    .file_addr_o(fa), .ram_addr_o(ra), .bit_num_o(bn), .src_addr_o(sa),
    .dst_addr_o(da), .literal_o(lit), .pointer_sel_o(psel), .fast_o(fst),
    .retire_o(ret), .flags_o(fl), .bank_select_register_o(bank_select_register),
    .table_pointer_o(tp), .tbl_stb_o(tstb), .tbl_write_o(twr),
    .tbl_addr_o(ta), .shadow_restore_o(srst), .shadow_acc_o(swr));
  idt_progmem u_idt_progmem (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .ready_i(irdy), .slow_i(slow), .word_o(iw), .valid_o(iv));
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  // Count retires, latch short pulses, and stall the memory at random.
  always @(posedge mclk_i) begin
    if (ret === 1'b1) n_ret <= n_ret + 1;
    if (tstb === 1'b1) {w_seen, t_seen} <= {twr, ta};
    if (srst === 1'b1) r_seen <= 1'b1;
    slow <= ($urandom % 4) == 0;
    ct <= $urandom;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Effective address: banked, or split access area when a is zero.
  function automatic logic [11:0] ram_exp(input logic a,
                                          input logic [3:0] b,
                                          input logic [7:0] f);
    if (a) return {b, f};
    return {(f < idt_pkg::ACC_SPLIT) ? 4'h0 : idt_pkg::ACC_HI_BANK, f};
  endfunction
  task automatic test_done;
    $display("mismatches=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // A request is held until the edge that samples the stall low.
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int i;
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    for (i = 0; i < 50; i++) begin
      @(posedge mclk_i);
      if (wt === 1'b0) break;
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk_i);
    if (i == 50) begin
      n_mismatch++;
      test_done;
    end
  endtask
  task automatic run(input logic [15:0] w1, input logic [15:0] w2,
                     input int nw);
    int i, t;
    t = n_ret + 1;
    u_idt_progmem.push(w1);
    if (nw == 2) u_idt_progmem.push(w2);
    for (i = 0; i < 200 && n_ret < t; i++) @(posedge mclk_i);
    @(posedge mclk_i);
    if (n_ret < t) begin
      n_mismatch++;
      test_done;
    end
  endtask
  // Main sequence: registers, each group, two-word forms, table, fast.
  initial begin
    logic [31:0] r;
    logic [7:0] f;
    logic [3:0] b;
    logic d, a;
    int k;
    logic [20:0] p, e;
    void'($urandom(32'h9dd9));
    repeat (12) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    for (k = 0; k < 5; k++) begin
      bus(0, 5'(k == 4 ? 24 : k * 4), 32'h0000_0000, r);
      chk(r, 32'h0000_0000);
    end
    bus(1, idt_pkg::OFF_FLAGS, 32'h0000_0016, r);
    bus(0, idt_pkg::OFF_FLAGS, 32'h0000_0000, r);
    chk(r, 32'h0000_0016);
    for (k = 0; k < 4; k++) begin
      f = (k == 0) ? 8'h7f : (k == 1) ? 8'h80 : 8'($urandom);
      {d, a, b} = $urandom;
      af <= $urandom;
      bus(1, idt_pkg::OFF_BANK, {28'h000_0000, b}, r);
      run(16'h2400 | {6'h00, d, a, f}, 16'h0000, 1);
      chk(grp, idt_pkg::GRP_BYTE);
      chk({df, ab, fa}, {d, a, f});
      chk(ra, ram_exp(a, b, f));
      chk(fl, af);
      run(16'h8000 | {4'h0, b[2:0], a, f}, 16'h0000, 1);
      chk({grp, bn, ab}, {idt_pkg::GRP_BIT, b[2:0], a});
      run({8'h0e, f}, 16'h0000, 1);
      chk(lit, f);
    end
    p = $urandom;
    run({4'hc, p[11:0]}, {4'hf, p[20:9]}, 2);
    chk({sa, da}, {p[11:0], p[20:9]});
    run({8'hee, 2'h0, 2'h2, p[3:0]}, {8'hf0, p[7:0]}, 2);
    chk({psel, lit}, {2'h2, 8'h00, p[3:0], p[7:0]});
    run({8'hef, p[7:0]}, {4'hf, p[19:8]}, 2);
    chk(lit, p[19:0]);
    run({4'hf, p[11:0]}, 16'h0000, 1);
    chk(grp, idt_pkg::GRP_CTRL);
    for (k = 0; k < 8; k++) begin
      p = $urandom;
      bus(1, idt_pkg::OFF_TBL_POINTER, 32'(p), r);
      run(16'h0008 + 16'(k), 16'h0000, 1);
      e = (k % 4 == 3) ? p + 21'h1 : p;
      chk({w_seen, t_seen}, {k > 3, e});
      chk(tp, k % 4 == 1 ? p + 21'h1 : k % 4 == 2 ? p - 21'h1 : e);
    end
    f = $urandom;
    acc <= f;
    run({8'hed, f}, 16'hf000, 2);
    chk(fst, 1'b1);
    r_seen = 1'b0;
    run(16'h0012, 16'h0000, 1);
    chk(r_seen, 1'b0);
    run(16'h0013, 16'h0000, 1);
    chk({r_seen, swr}, {1'b1, f});
    run(16'h0105, 16'h0000, 1);
    chk(bank_select_register, 4'h5);
    // Extended call counts as a jump only while the extension is on.
    bus(1, idt_pkg::OFF_CTRL, 32'h0000_0001, r);
    run(16'h0014, 16'h0000, 1);
    bus(0, idt_pkg::OFF_INFO, 32'h0000_0000, r);
    chk(r[20:0], {1'b1, 2'h2, idt_pkg::GRP_CTRL, 16'h0014});
    bus(1, idt_pkg::OFF_CTRL, 32'h0000_0000, r);
    run(16'h0014, 16'h0000, 1);
    bus(0, idt_pkg::OFF_INFO, 32'h0000_0000, r);
    chk(r[20:0], {1'b0, 2'h1, idt_pkg::GRP_CTRL, 16'h0014});
    bus(0, idt_pkg::OFF_RETIRED, 32'h0000_0000, r);
    chk(r, 32'(n_ret));
    test_done;
  end
endmodule
bind idt_core idt_checker u_idt_checker (.mclk_i(mclk_i), .rstn_i(rstn_i),
  .read_i(read_i), .write_i(write_i), .waitrequest_o(waitrequest_o),
  .instr_ready_o(instr_ready_o), .q_phase_o(q_phase_o),
  .state_o(state_o), .retire_o(retire_o), .flags_o(flags_o));
